// *** inc/hrc_pkg.sv ***
// Constants shared by the hard-reset configuration sampler
package hrc_pkg;
	// Register offsets (byte addresses)
	localparam logic [3:0] PAD_CFG_OFS   = 4'h0;
	localparam logic [3:0] SYS_STAT_OFS  = 4'h4;
	localparam logic [3:0] BANK0_OPT_OFS = 4'h8;
	localparam logic [3:0] MSTATE_OFS    = 4'hc;

	// Configuration word: bit 0 is the MSB, so field n sits at index 31-n
	localparam int CFG_ARB_POS    = 31;
	localparam int CFG_PFX_POS    = 30;
	localparam int CFG_DRV_POS    = 29;
	localparam int CFG_BTDIS_POS  = 28;
	localparam int CFG_PW_LO_POS  = 26;
	localparam int CFG_DBG_LO_POS = 21;

	// Flag position in the stored word; erased flash reads all ones
	localparam int NVM_HAS_CFG_POS = 0;

	localparam logic [31:0] CFG_DEFAULT_WORD = 32'h0000_0000;

	// Register field positions
	localparam int PAD_PD_SEL_POS = 0;
	localparam int BANK0_DIS_POS  = 0;
	localparam int BANK0_PS_LO    = 1;
	localparam int MSTATE_PFX_POS = 0;

	// Source codes seen in the status register
	localparam logic [1:0] SRC_DEFAULT = 2'h0;
	localparam logic [1:0] SRC_PINS    = 2'h1;
	localparam logic [1:0] SRC_NVM     = 2'h2;

	// Sampling period in bus clocks
	localparam int          SAMPLE_PERIOD = 8;
	localparam logic [2:0]  SAMPLE_LAST   = 3'(SAMPLE_PERIOD - 1);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/hrc_sampler.sv ***
// Hard-reset configuration word sampler with AXI4-Lite register access
// Functional notes
// - Select asserted at sampling: configuration comes from the 32 data pins.
// - Select negated, stored flag 0: configuration comes from the stored word.
// - Select negated, stored flag 1: configuration is the all-zero constant.
// - Erased flash makes the stored flag read 1, forcing the default word.
// - Pull-down bit set, hard reset and select asserted: data lines pulled low weakly.
// - Default configuration applies for the whole power-on reset.
// - Sampled values replace the default once power-on reset releases.
// - Source re-sampled every eight bus clocks through a two-stage buffer.
// - Final word captured from the buffer when hard reset negates.
// - Captured word is not mapped; it seeds control fields in registers.
// - Bit 0: 0 internal arbitration, 1 external arbiter assumed.
// - Bit 1 loads the vector prefix state bit after reset.
// - Bit 2: 0 full drive, 1 reduced drive on bus pins.
// - Bit 3: 0 boot bank active; later bank-0 option write overrides.
// - Bits 4:5 boot port width; ignored once bank-0 option is written.
// - Bits 9:10 select the debug pin function, default zero.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module hrc_sampler (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        power_on_reset_n,
	input  wire logic        hard_reset_n,
	input  wire logic        reset_config_select_n,
	input  wire logic [31:0] data_pins,
	input  wire logic [31:0] nvm_config_word,
	input  wire logic        flash_erased,
	output logic             data_pulldown_en,
	output logic             external_arbitration_sel,
	output logic             vector_prefix_init,
	output logic             bus_drive_strength,
	output logic             boot_bank_disable,
	output logic [1:0]       boot_port_width,
	output logic [1:0]       debug_pin_config
);
	// Pin synchronisers
	logic        por_n_s1_reg;
	logic        por_n_s2_reg;
	logic        hr_n_s1_reg;
	logic        hr_n_s2_reg;
	logic        hr_n_d_reg;
	logic        sel_n_s1_reg;
	logic        sel_n_s2_reg;
	logic        erased_s1_reg;
	logic        erased_s2_reg;
	logic [31:0] data_s1_reg;
	logic [31:0] data_s2_reg;

	logic [2:0]  tick_cnt_reg;
	logic [31:0] stage1_reg;
	logic [31:0] stage2_reg;
	logic [1:0]  src_next;
	logic [1:0]  src_reg;
	logic [31:0] sample_next;
	logic [31:0] cfg_word_reg;
	logic        has_cfg_n;
	logic        tick;
	logic        hr_rise;

	logic        pd_sel_reg;
	logic [2:0]  bank0_reg;
	logic        bank0_written_reg;

	logic        aw_have_reg;
	logic        w_have_reg;
	logic [3:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;
	logic        wr_ok;
	logic [31:0] rd_next;
	logic        rd_ok;

	assign tick    = (tick_cnt_reg == hrc_pkg::SAMPLE_LAST);
	assign hr_rise = hr_n_s2_reg & ~hr_n_d_reg;
	assign wr_fire = ce & aw_have_reg & w_have_reg & ~s_axi_bvalid;
	assign wr_ok   = (aw_addr_reg == hrc_pkg::PAD_CFG_OFS) |
		(aw_addr_reg == hrc_pkg::BANK0_OPT_OFS) | (aw_addr_reg == hrc_pkg::MSTATE_OFS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_n_s1_reg  <= 1'b0;
			por_n_s2_reg  <= 1'b0;
			hr_n_s1_reg   <= 1'b0;
			hr_n_s2_reg   <= 1'b0;
			hr_n_d_reg    <= 1'b0;
			sel_n_s1_reg  <= 1'b1;
			sel_n_s2_reg  <= 1'b1;
			erased_s1_reg <= 1'b0;
			erased_s2_reg <= 1'b0;
			data_s1_reg   <= 32'h0000_0000;
			data_s2_reg   <= 32'h0000_0000;
		end else if (ce) begin
			por_n_s1_reg  <= power_on_reset_n;
			por_n_s2_reg  <= por_n_s1_reg;
			hr_n_s1_reg   <= hard_reset_n;
			hr_n_s2_reg   <= hr_n_s1_reg;
			hr_n_d_reg    <= hr_n_s2_reg;
			sel_n_s1_reg  <= reset_config_select_n;
			sel_n_s2_reg  <= sel_n_s1_reg;
			erased_s1_reg <= flash_erased;
			erased_s2_reg <= erased_s1_reg;
			data_s1_reg   <= data_pins;
			data_s2_reg   <= data_s1_reg;
		end
	end

	// Erased flash forces the flag high even if the array reads oddly
	assign has_cfg_n = nvm_config_word[hrc_pkg::NVM_HAS_CFG_POS] | erased_s2_reg;

	always_comb begin
		if (!sel_n_s2_reg) begin
			sample_next = data_s2_reg;
			src_next    = hrc_pkg::SRC_PINS;
		end else if (!has_cfg_n) begin
			sample_next = nvm_config_word;
			src_next    = hrc_pkg::SRC_NVM;
		end else begin
			sample_next = hrc_pkg::CFG_DEFAULT_WORD;
			src_next    = hrc_pkg::SRC_DEFAULT;
		end
	end

	// Sampling runs while hard reset holds; power-on reset pins the default
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_reg <= 3'h0;
			stage1_reg   <= hrc_pkg::CFG_DEFAULT_WORD;
			stage2_reg   <= hrc_pkg::CFG_DEFAULT_WORD;
			src_reg      <= hrc_pkg::SRC_DEFAULT;
		end else if (ce) begin
			if (!por_n_s2_reg) begin
				tick_cnt_reg <= 3'h0;
				stage1_reg   <= hrc_pkg::CFG_DEFAULT_WORD;
				stage2_reg   <= hrc_pkg::CFG_DEFAULT_WORD;
				src_reg      <= hrc_pkg::SRC_DEFAULT;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 3'h1;
				if (tick && !hr_n_s2_reg) begin
					stage1_reg <= sample_next;
					stage2_reg <= stage1_reg;
					src_reg    <= src_next;
				end
			end
		end
	end

	// Word is internal only; it is never returned on the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_word_reg <= hrc_pkg::CFG_DEFAULT_WORD;
		end else if (ce) begin
			if (!por_n_s2_reg) begin
				cfg_word_reg <= hrc_pkg::CFG_DEFAULT_WORD;
			end else if (hr_rise) begin
				cfg_word_reg <= stage2_reg;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_pulldown_en <= 1'b0;
		end else if (ce) begin
			data_pulldown_en <= pd_sel_reg & ~hr_n_s2_reg & ~sel_n_s2_reg;
		end
	end

	// Decoded fields; reserved positions are simply not looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			external_arbitration_sel <= 1'b0;
			bus_drive_strength       <= 1'b0;
			boot_bank_disable        <= 1'b0;
			boot_port_width          <= 2'h0;
			debug_pin_config         <= 2'h0;
		end else if (ce) begin
			external_arbitration_sel <= cfg_word_reg[hrc_pkg::CFG_ARB_POS];
			bus_drive_strength       <= cfg_word_reg[hrc_pkg::CFG_DRV_POS];
			debug_pin_config <= cfg_word_reg[hrc_pkg::CFG_DBG_LO_POS +: 2];
			if (bank0_written_reg) begin
				boot_bank_disable <= bank0_reg[hrc_pkg::BANK0_DIS_POS];
				boot_port_width   <= bank0_reg[hrc_pkg::BANK0_PS_LO +: 2];
			end else begin
				boot_bank_disable <= cfg_word_reg[hrc_pkg::CFG_BTDIS_POS];
				boot_port_width   <= cfg_word_reg[hrc_pkg::CFG_PW_LO_POS +: 2];
			end
		end
	end

	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_sel_reg <= 1'b0;
		end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == hrc_pkg::PAD_CFG_OFS) begin
			pd_sel_reg <= w_data_reg[hrc_pkg::PAD_PD_SEL_POS];
		end
	end

	// A new hard reset returns boot control to the configuration word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank0_reg         <= 3'h0;
			bank0_written_reg <= 1'b0;
		end else if (ce) begin
			if (!hr_n_s2_reg) begin
				bank0_written_reg <= 1'b0;
			end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == hrc_pkg::BANK0_OPT_OFS) begin
				bank0_reg         <= w_data_reg[2:0];
				bank0_written_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vector_prefix_init <= 1'b0;
		end else if (ce) begin
			if (hr_rise) begin
				vector_prefix_init <= stage2_reg[hrc_pkg::CFG_PFX_POS];
			end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == hrc_pkg::MSTATE_OFS) begin
				vector_prefix_init <= w_data_reg[hrc_pkg::MSTATE_PFX_POS];
			end
		end
	end

	// AXI4-Lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= hrc_pkg::RESP_OKAY;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 4'h0;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg   <= 1'b1;
				aw_addr_reg   <= {s_axi_awaddr[3:2], 2'h0};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg   <= 1'b1;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? hrc_pkg::RESP_OKAY : hrc_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		rd_ok   = 1'b1;
		unique case ({s_axi_araddr[3:2], 2'h0})
			hrc_pkg::PAD_CFG_OFS:   rd_next[hrc_pkg::PAD_PD_SEL_POS] = pd_sel_reg;
			hrc_pkg::SYS_STAT_OFS:  rd_next[10:0] = {~hr_n_s2_reg, src_reg, bank0_written_reg,
				debug_pin_config, boot_port_width, boot_bank_disable,
				bus_drive_strength, external_arbitration_sel};
			hrc_pkg::BANK0_OPT_OFS: rd_next[2:0] = bank0_reg;
			hrc_pkg::MSTATE_OFS:    rd_next[hrc_pkg::MSTATE_PFX_POS] = vector_prefix_init;
			default:                rd_ok = 1'b0;
		endcase
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= hrc_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_next;
				s_axi_rresp   <= rd_ok ? hrc_pkg::RESP_OKAY : hrc_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_pin_source: assert property (ce && por_n_s2_reg && tick && !hr_n_s2_reg
		&& !sel_n_s2_reg |=> stage1_reg == $past(data_s2_reg))
		else $error("pin word not sampled");
	a_nvm_source: assert property (ce && por_n_s2_reg && tick && !hr_n_s2_reg
		&& sel_n_s2_reg && !has_cfg_n |=> stage1_reg == $past(nvm_config_word))
		else $error("stored word not sampled");
	a_default_src: assert property (ce && por_n_s2_reg && tick && !hr_n_s2_reg
		&& sel_n_s2_reg && erased_s2_reg |=> stage1_reg == 32'h0000_0000)
		else $error("erased flash not default");
	a_pulldown_cond: assert property (ce && pd_sel_reg && !hr_n_s2_reg
		&& !sel_n_s2_reg |=> data_pulldown_en)
		else $error("pull-down not applied");
	a_por_default: assert property (ce && !por_n_s2_reg
		|=> stage2_reg == 32'h0000_0000 && cfg_word_reg == 32'h0000_0000)
		else $error("default not held in power-on reset");
	a_stage_shift: assert property (ce && por_n_s2_reg && !tick
		|=> $stable(stage1_reg) && $stable(stage2_reg))
		else $error("buffer moved off tick");
	a_word_capture: assert property (ce && por_n_s2_reg && hr_rise
		|=> cfg_word_reg == $past(stage2_reg)) else $error("word not captured");
	a_word_hold: assert property (ce && por_n_s2_reg && hr_n_s2_reg
		&& hr_n_d_reg |=> $stable(cfg_word_reg)) else $error("word changed outside reset");
	a_arb_decode: assert property (ce ##1 ce
		|=> external_arbitration_sel == $past(cfg_word_reg[hrc_pkg::CFG_ARB_POS]))
		else $error("arbitration field wrong");
	a_boot_override: assert property (ce && bank0_written_reg
		|=> boot_bank_disable == $past(bank0_reg[hrc_pkg::BANK0_DIS_POS]))
		else $error("bank-0 write did not override");

	c_pin_capture: cover property (hr_rise && src_reg == hrc_pkg::SRC_PINS);
	c_nvm_capture: cover property (hr_rise && src_reg == hrc_pkg::SRC_NVM);
	c_bank0_write: cover property (ce && bank0_written_reg ##1 !hr_n_s2_reg);
endmodule

// *** tb/hrc_board_model.sv ***
// Board-side model that drives the configuration word onto the data pins
`timescale 1ns/1ns
module hrc_board_model (
	input  wire logic        aclk,
	input  wire logic        drive_en,
	input  wire logic [31:0] drive_word,
	input  wire logic        pulldown_en,
	output logic [31:0]      data_pins
);
	logic [31:0] float_pat = 32'h5555_5555;
	logic [31:0] ones;

	// Undriven lines toggle every clock unless the pull-down holds them low
	always @(posedge aclk) begin
		float_pat <= ~float_pat;
	end

	// Only ones are driven, hard enough to beat the weak pull-down
	assign ones = drive_en ? drive_word : 32'h0000_0000;
	assign data_pins = ones | (pulldown_en ? 32'h0000_0000 : (float_pat & ~ones));
endmodule

// *** tb/tb_top.sv ***
// Self-checking testbench for the hard-reset configuration sampler
`timescale 1ns/1ns
module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, data_pins, rd;
	logic [31:0] nvm_word = 32'h0000_0001;
	logic [31:0] board_word = 32'hffff_ffff;
	logic        por_n = 1'b0, sel_n = 1'b1, erased = 1'b0, board_drive = 1'b0;
	logic        hard_reset_n = 1'b0, ce = 1'b1;
	logic        pd_en, ext_arb, vec_pfx, drv_red, boot_dis;
	logic [1:0]  port_w, dbg, r;
	int          num_errors = 0;
	int          n_compared = 0;

	always #5 aclk = ~aclk;

	hrc_board_model i_board (.aclk(aclk), .drive_en(board_drive), .drive_word(board_word),
		.pulldown_en(pd_en), .data_pins(data_pins));

	hrc_sampler i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.power_on_reset_n(por_n), .hard_reset_n(hard_reset_n), .reset_config_select_n(sel_n),
		.data_pins(data_pins), .nvm_config_word(nvm_word), .flash_erased(erased),
		.data_pulldown_en(pd_en), .external_arbitration_sel(ext_arb),
		.vector_prefix_init(vec_pfx), .bus_drive_strength(drv_red),
		.boot_bank_disable(boot_dis), .boot_port_width(port_w),
		.debug_pin_config(dbg));

	task automatic finish_test();
		$display("errors %0d, compares %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic timed_out();
		$display("ERROR at %0t: got %h expected %h", $time, 32'h0, 32'h1);
		num_errors++;
		finish_test();
	endtask

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		if (i == 50) timed_out();
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		if (i == 50) timed_out();
		d = rdata;
		chk({30'h0, rresp}, {30'h0, hrc_pkg::RESP_OKAY});
		rready <= 1'b0;
	endtask

	// Word bit n sits at index 31-n
	task automatic check_cfg(input logic [31:0] w);
		chk({24'h0, ext_arb, vec_pfx, drv_red, boot_dis, port_w, dbg},
			{24'h0, w[31], w[30], w[29], w[28], w[27], w[26], w[22], w[21]});
	endtask

	// Source held well past two sampling ticks, then a fast hard reset release
	task automatic hard_reset_cycle(input logic sel, input logic drive, input logic exp_pd);
		@(posedge aclk);
		hard_reset_n <= 1'b0;
		sel_n <= sel;
		board_drive <= drive;
		repeat (12) @(posedge aclk);
		chk({31'h0, pd_en}, {31'h0, exp_pd});
		repeat (40) @(posedge aclk);
		hard_reset_n <= 1'b1;
		repeat (8) @(posedge aclk);
		board_drive <= 1'b0;
		sel_n <= 1'b1;
		@(posedge aclk);
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_write(hrc_pkg::PAD_CFG_OFS, 32'h0000_0001, r);
		chk({30'h0, r}, {30'h0, hrc_pkg::RESP_OKAY});
		hard_reset_cycle(1'b0, 1'b1, 1'b1);
		check_cfg(hrc_pkg::CFG_DEFAULT_WORD);
		por_n <= 1'b1;
		board_word <= 32'ha440_0000;
		hard_reset_cycle(1'b0, 1'b1, 1'b1);
		check_cfg(32'ha440_0000);
		axi_read(hrc_pkg::SYS_STAT_OFS, rd);
		chk({30'h0, rd[9:8]}, {30'h0, hrc_pkg::SRC_PINS});
		axi_read(hrc_pkg::MSTATE_OFS, rd);
		chk({31'h0, rd[0]}, 32'h0000_0000);
		board_word <= 32'hffff_ffff;
		board_drive <= 1'b1;
		sel_n <= 1'b0;
		repeat (40) @(posedge aclk);
		check_cfg(32'ha440_0000);
		board_drive <= 1'b0;
		sel_n <= 1'b1;
		axi_write(hrc_pkg::BANK0_OPT_OFS, 32'h0000_0005, r);
		chk({30'h0, r}, {30'h0, hrc_pkg::RESP_OKAY});
		repeat (3) @(posedge aclk);
		chk({29'h0, boot_dis, port_w}, 32'h0000_0006);
		axi_write(hrc_pkg::SYS_STAT_OFS, 32'hffff_ffff, r);
		chk({30'h0, r}, {30'h0, hrc_pkg::RESP_SLVERR});
		axi_read(hrc_pkg::SYS_STAT_OFS, rd);
		chk({31'h0, rd[7]}, 32'h0000_0001);
		axi_write(hrc_pkg::PAD_CFG_OFS, 32'h0000_0000, r);
		chk({30'h0, r}, {30'h0, hrc_pkg::RESP_OKAY});
		nvm_word <= 32'h5860_0000;
		hard_reset_cycle(1'b1, 1'b0, 1'b0);
		check_cfg(32'h5860_0000);
		axi_read(hrc_pkg::SYS_STAT_OFS, rd);
		chk({30'h0, rd[9:8]}, {30'h0, hrc_pkg::SRC_NVM});
		axi_read(hrc_pkg::MSTATE_OFS, rd);
		chk({31'h0, rd[0]}, 32'h0000_0001);
		// Frozen clock enable must hide a power-on pulse from every flop
		ce <= 1'b0;
		por_n <= 1'b0;
		repeat (10) @(posedge aclk);
		por_n <= 1'b1;
		repeat (4) @(posedge aclk);
		ce <= 1'b1;
		repeat (4) @(posedge aclk);
		check_cfg(32'h5860_0000);
		nvm_word <= 32'h5860_0001;
		hard_reset_cycle(1'b1, 1'b0, 1'b0);
		check_cfg(hrc_pkg::CFG_DEFAULT_WORD);
		axi_read(hrc_pkg::SYS_STAT_OFS, rd);
		chk({30'h0, rd[9:8]}, {30'h0, hrc_pkg::SRC_DEFAULT});
		nvm_word <= 32'h5860_0000;
		erased <= 1'b1;
		hard_reset_cycle(1'b1, 1'b0, 1'b0);
		check_cfg(hrc_pkg::CFG_DEFAULT_WORD);
		finish_test();
	end
endmodule
